// ### shared/aio_consts.svh
`ifndef AIO_CONSTS_SVH
`define AIO_CONSTS_SVH

// ********************************************************************
// Clock and bus placement
// ********************************************************************
`define MCLK_PERIOD_NS 8
`define SLOT_BASE      16'hC000
`define REG_IDX_W      4

// Register indices; byte address on the bus is four times the index
`define REG_CH0        4'h0
`define REG_CH1        4'h2
`define REG_CH2        4'h4
`define REG_CH3        4'h6
`define REG_CFG        4'h8
`define REG_SEL        4'hA
`define REG_STAT       4'hC
`define REG_IACK       4'hE

// ********************************************************************
// Field layout and reset values
// ********************************************************************
`define CFG_AC_BIT     15
`define CFG_INT_BIT    14
`define CFG_TA_LSB     0
`define CFG_TA_MSB     2
`define SEL_LSB        0
`define SEL_MSB        2
`define STAT_EOC_BIT   0
`define STAT_VERR_BIT  1
`define DAC_MSB        15
`define DAC_LSB        4
`define DAC_PAD        4'h0
`define DAC_RESET      16'h0000
`define SEL_RESET      3'h1
`define TA_RESET       3'h0

// Cycle time selection codes
`define TA_CODE0       3'h0
`define TA_CODE1       3'h1
`define TA_CODE2       3'h3
`define TA_CODE3       3'h4

// ********************************************************************
// Timing
// ********************************************************************
`define CYC_TA0_NS     5700000
`define CYC_TA1_NS     2800000
`define CYC_TA2_NS     600000
`define CYC_TA3_NS     185000
`define MUX_SETTLE_NS  2000

`endif

// ### shared/aio_pkg.sv
package aio_pkg;

  typedef struct packed {
    logic       auto_en;
    logic       irq_en;
    logic [2:0] cycle_sel;
  } cfg_t;

  typedef struct packed {
    logic        done;
    logic        volt_err;
    logic [15:0] data;
  } adc_ret_t;

  typedef struct packed {
    logic [1:0]       load;
    logic [1:0][15:0] value;
  } dac_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_CONVERT,
    ST_CYC_WAIT
  } conv_state_t;

endpackage

// ### logic/result_mem.sv
`timescale 1ns/1ps

module result_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  // Cleared at reset so results read as zero before any conversion
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (re) begin
      rdata_q <= mem_q[raddr];
    end
  end

  assign rdata = rdata_q;

endmodule // result_mem

// ### logic/aio_regs.sv
`timescale 1ns/1ps
`include "aio_consts.svh"

module aio_regs #(
  parameter logic [15:0] SLOT_BASE   = `SLOT_BASE,
  parameter int unsigned CYC0_CYCLES = `CYC_TA0_NS / `MCLK_PERIOD_NS,
  parameter int unsigned CYC1_CYCLES = `CYC_TA1_NS / `MCLK_PERIOD_NS,
  parameter int unsigned CYC2_CYCLES = `CYC_TA2_NS / `MCLK_PERIOD_NS,
  parameter int unsigned CYC3_CYCLES = `CYC_TA3_NS / `MCLK_PERIOD_NS
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [15:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic      [31:0]      prdata,
  output logic                  pslverr,
  input  aio_pkg::adc_ret_t     adc_in,
  output logic                  adc_start,
  output logic      [1:0]       adc_mux,
  output aio_pkg::dac_cmd_t     dac_out,
  output logic                  irq
);

  // ******************************************************************
  // Constants
  // ******************************************************************
  localparam int unsigned SETTLE_CYC =
    (`MUX_SETTLE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS;
  localparam int TMR_W  = 20;
  localparam int SCNT_W = 12;

  // ******************************************************************
  // Functions
  // ******************************************************************
  function automatic logic addr_hit(input logic [15:0] a);
    addr_hit = (a[15:6] == SLOT_BASE[15:6]) &&
               (a[1:0] == 2'h0) && !a[2];
  endfunction

  function automatic logic [1:0] chan_num(input logic [2:0] f);
    logic [2:0] n;
    n        = f - 3'h1;
    chan_num = n[1:0];
  endfunction

  function automatic logic [TMR_W-1:0] cyc_last(input logic [2:0] ta);
    int unsigned c;
    case (ta)
      `TA_CODE0: c = CYC0_CYCLES;
      `TA_CODE1: c = CYC1_CYCLES;
      `TA_CODE2: c = CYC2_CYCLES;
      `TA_CODE3: c = CYC3_CYCLES;
      default:   c = CYC3_CYCLES;
    endcase
    cyc_last = TMR_W'(c - 1);
  endfunction

  // ******************************************************************
  // Declarations
  // ******************************************************************
  logic                       pready_q;
  logic [31:0]                prdata_q;
  logic                       pslverr_q;
  logic                       adc_start_q;
  logic [1:0]                 adc_mux_q;
  aio_pkg::dac_cmd_t          dac_q;
  logic                       irq_q;
  aio_pkg::cfg_t              cfg_q;
  logic [2:0]                 sel_q;
  logic                       eoc_q;
  logic                       verr_q;
  aio_pkg::conv_state_t       state_q;
  logic                       auto_q;
  logic [1:0]                 ch_q;
  logic [SCNT_W-1:0]          scnt_q;
  logic [TMR_W-1:0]           tmr_q;
  logic [`REG_IDX_W-1:0]      idx;
  logic                       hit;
  logic                       acc_first;
  logic                       acc_done;
  logic                       wr_ok;
  logic                       demand_go;
  logic                       conv_done;
  logic                       conv_begin;
  logic                       cycle_start;
  logic                       cycle_end;
  logic                       tmr_done;
  logic                       settle_done;
  logic [15:0]                mem_rdata;

  // ******************************************************************
  // Bus decode
  // ******************************************************************
  // One wait state: the result memory answers a cycle after setup
  assign idx       = paddr[5:2];
  assign hit       = addr_hit(paddr);
  assign acc_first = psel && penable && !pready_q;
  assign acc_done  = psel && penable && pready_q;
  assign wr_ok     = acc_done && pwrite && hit;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= acc_first;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= acc_first && !hit;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (acc_first) begin
      prdata_q <= 32'h0000_0000;
      if (hit && !pwrite) begin
        case (idx)
          `REG_CH0, `REG_CH1, `REG_CH2, `REG_CH3: begin
            prdata_q[15:0] <= mem_rdata;
          end
          `REG_CFG: begin
            prdata_q[`CFG_AC_BIT]              <= cfg_q.auto_en;
            prdata_q[`CFG_INT_BIT]             <= cfg_q.irq_en;
            prdata_q[`CFG_TA_MSB:`CFG_TA_LSB]  <= cfg_q.cycle_sel;
          end
          `REG_SEL: begin
            prdata_q[`SEL_MSB:`SEL_LSB] <= sel_q;
          end
          `REG_STAT: begin
            prdata_q[`STAT_EOC_BIT]  <= eoc_q;
            prdata_q[`STAT_VERR_BIT] <= verr_q;
          end
          default: begin
            prdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ******************************************************************
  // Result memory
  // ******************************************************************
  assign conv_done = (state_q == aio_pkg::ST_CONVERT) && adc_in.done;

  result_mem #(
    .WIDTH (16),
    .DEPTH (4),
    .AW    (2)
  ) u_results (
    .mclk  (mclk),
    .rst_n (rst_n),
    .we    (conv_done),
    .waddr (ch_q),
    .wdata (adc_in.data),
    .re    (psel && !penable),
    .raddr (paddr[4:3]),
    .rdata (mem_rdata)
  );

  // ******************************************************************
  // Configuration and channel select
  // ******************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_q.auto_en   <= 1'b0;
      cfg_q.irq_en    <= 1'b0;
      cfg_q.cycle_sel <= `TA_RESET;
    end else if (wr_ok && idx == `REG_CFG) begin
      cfg_q.auto_en   <= pwdata[`CFG_AC_BIT];
      cfg_q.irq_en    <= pwdata[`CFG_INT_BIT];
      cfg_q.cycle_sel <= pwdata[`CFG_TA_MSB:`CFG_TA_LSB];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sel_q <= `SEL_RESET;
    end else if (wr_ok && idx == `REG_SEL) begin
      sel_q <= pwdata[`SEL_MSB:`SEL_LSB];
    end
  end

  // ******************************************************************
  // Output channels
  // ******************************************************************
  // Low nibble forced to zero so a careless host cannot add offset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dac_q.load  <= 2'h0;
      dac_q.value <= {`DAC_RESET, `DAC_RESET};
    end else begin
      dac_q.load <= 2'h0;
      if (wr_ok && (idx == `REG_CH0 || idx == `REG_CH1)) begin
        dac_q.load[idx[1]]  <= 1'b1;
        dac_q.value[idx[1]] <=
          {pwdata[`DAC_MSB:`DAC_LSB], `DAC_PAD};
      end
    end
  end

  // ******************************************************************
  // Conversion sequencer
  // ******************************************************************
  // A demand start while a sequence runs is dropped
  assign demand_go   = wr_ok && idx == `REG_STAT &&
                       state_q == aio_pkg::ST_IDLE && !cfg_q.auto_en;
  assign tmr_done    = tmr_q >= cyc_last(cfg_q.cycle_sel);
  assign settle_done = scnt_q == SCNT_W'(SETTLE_CYC - 1);
  assign cycle_start = cfg_q.auto_en &&
                       (state_q == aio_pkg::ST_IDLE ||
                        (state_q == aio_pkg::ST_CYC_WAIT && tmr_done));
  assign cycle_end   = conv_done && auto_q && ch_q == 2'h3;
  assign conv_begin  = demand_go || cycle_start;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q     <= aio_pkg::ST_IDLE;
      auto_q      <= 1'b0;
      ch_q        <= 2'h0;
      scnt_q      <= '0;
      adc_start_q <= 1'b0;
      adc_mux_q   <= 2'h0;
    end else begin
      adc_start_q <= 1'b0;
      case (state_q)
        aio_pkg::ST_IDLE: begin
          scnt_q <= '0;
          if (cycle_start) begin
            auto_q    <= 1'b1;
            ch_q      <= 2'h0;
            adc_mux_q <= 2'h0;
            state_q   <= aio_pkg::ST_SETTLE;
          end else if (demand_go) begin
            auto_q    <= 1'b0;
            ch_q      <= chan_num(sel_q);
            adc_mux_q <= chan_num(sel_q);
            state_q   <= aio_pkg::ST_SETTLE;
          end
        end
        aio_pkg::ST_SETTLE: begin
          scnt_q <= scnt_q + 1'b1;
          if (settle_done) begin
            adc_start_q <= 1'b1;
            state_q     <= aio_pkg::ST_CONVERT;
          end
        end
        aio_pkg::ST_CONVERT: begin
          scnt_q <= '0;
          if (adc_in.done) begin
            if (!auto_q || !cfg_q.auto_en) begin
              state_q <= aio_pkg::ST_IDLE;
            end else if (ch_q == 2'h3) begin
              state_q <= aio_pkg::ST_CYC_WAIT;
            end else begin
              ch_q      <= ch_q + 2'h1;
              adc_mux_q <= ch_q + 2'h1;
              state_q   <= aio_pkg::ST_SETTLE;
            end
          end
        end
        aio_pkg::ST_CYC_WAIT: begin
          if (!cfg_q.auto_en) begin
            state_q <= aio_pkg::ST_IDLE;
          end else if (tmr_done) begin
            ch_q      <= 2'h0;
            adc_mux_q <= 2'h0;
            state_q   <= aio_pkg::ST_SETTLE;
          end
        end
        default: begin
          state_q <= aio_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Cycle timer saturates when slots overrun the chosen cycle time
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tmr_q <= '0;
    end else if (cycle_start) begin
      tmr_q <= '0;
    end else if (!tmr_done) begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  // ******************************************************************
  // Status and interrupt
  // ******************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      eoc_q  <= 1'b0;
      verr_q <= 1'b0;
    end else if (conv_done) begin
      eoc_q  <= 1'b1;
      verr_q <= adc_in.volt_err;
    end else if (conv_begin) begin
      eoc_q  <= 1'b0;
      verr_q <= 1'b0;
    end
  end

  // Raise wins over an acknowledge in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (cycle_end && cfg_q.irq_en) begin
      irq_q <= 1'b1;
    end else if (wr_ok && idx == `REG_IACK) begin
      irq_q <= 1'b0;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign pready    = pready_q;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q;
  assign adc_start = adc_start_q;
  assign adc_mux   = adc_mux_q;
  assign dac_out   = dac_q;
  assign irq       = irq_q;

endmodule // aio_regs

// ### verification/aio_regs_checker.sv
`timescale 1ns/1ps

module aio_regs_checker #(
  parameter logic [15:0] SLOT_BASE = 16'hC000
) (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [15:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire aio_pkg::adc_ret_t adc_in,
  input wire logic              adc_start,
  input wire logic [1:0]        adc_mux,
  input wire aio_pkg::dac_cmd_t dac_out,
  input wire logic              irq
);
  // ****
  // Helpers
  // ****
  logic        fin;
  logic        wr_q;
  logic        done_q;
  logic [15:0] wd_q;

  assign fin = psel && penable && pready;

  always_ff @(posedge mclk) begin
    wr_q   <= fin && pwrite;
    done_q <= adc_in.done;
    wd_q   <= {pwdata[15:4], 4'h0};
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ****
  // Properties
  // ****
  rdy_wait_a: assert property (psel && !penable |=> ##1 pready)
    else $error("ready not in second access cycle");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  bad_base_a: assert property (fin && paddr[15:6] != SLOT_BASE[15:6]
    |-> pslverr && prdata == 32'h0000_0000)
    else $error("access outside slot not refused");
  bad_align_a: assert property (fin && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access not refused");
  hi_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  dac_load_a: assert property (fin && pwrite && paddr == SLOT_BASE
    |=> dac_out.load[0] && dac_out.value[0] == wd_q)
    else $error("output 0 not loaded left-justified");
  dac_cause_a: assert property (dac_out.load != 2'b00 |-> wr_q)
    else $error("output load without a write");
  dac_hold_a: assert property (!wr_q |-> $stable(dac_out.value))
    else $error("output value changed without a write");
  irq_hold_a: assert property (irq && !(fin && pwrite
    && paddr == SLOT_BASE + 16'h0038) |=> irq)
    else $error("interrupt dropped without acknowledge");
  irq_cause_a: assert property ($rose(irq) |-> done_q)
    else $error("interrupt without a finished conversion");

  irq_seen_c: cover property (irq);
  load1_c: cover property (dac_out.load[1]);
  refuse_c: cover property (fin && pslverr);
endmodule // aio_regs_checker

bind aio_regs aio_regs_checker #(.SLOT_BASE(SLOT_BASE)) chk (
  .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .pslverr, .adc_in, .adc_start, .adc_mux, .dac_out, .irq);

// ### verification/adc_model.sv
`timescale 1ns/1ps

module adc_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        adc_start,
  input  wire logic [1:0]  adc_mux,
  output aio_pkg::adc_ret_t adc_in
);
  // Short fixed conversion so four slots fit well inside a cycle
  logic [4:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) cnt_q <= 5'h00;
    else if (adc_start) cnt_q <= 5'h14;
    else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
  end

  // Outside done the lines wander, so a stale sample cannot pass
  always_ff @(posedge mclk) begin
    if (!rst_n) adc_in <= '0;
    else if (cnt_q == 5'h01)
      adc_in <= {1'b1, adc_mux == 2'h3, 12'h8A5, 2'b00, adc_mux};
    else adc_in <= {1'b0, ~adc_in.volt_err, ~adc_in.data};
  end
endmodule // adc_model

// ### verification/aio_regs_tb_top.sv
`timescale 1ns/1ps
`include "aio_consts.svh"

module aio_regs_tb_top;
  localparam int CYC [4] = '{1200, 1300, 1400, 1500};
  logic              mclk = 1'b0;
  logic              rst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [15:0]       paddr;
  logic [31:0]       pwdata;
  logic              pready;
  logic [31:0]       prdata;
  logic              pslverr;
  aio_pkg::adc_ret_t adc_in;
  logic              adc_start;
  logic [1:0]        adc_mux;
  aio_pkg::dac_cmd_t dac_out;
  logic              irq;
  int                errors;
  int                num_checks;
  int                seed;
  int                cyc;
  logic [33:0]       exp_q[$];
  logic [17:0]       dac_q[$];
  logic [33:0]       e;
  logic [17:0]       f;

  aio_regs #(.CYC0_CYCLES(CYC[0]), .CYC1_CYCLES(CYC[1]),
    .CYC2_CYCLES(CYC[2]), .CYC3_CYCLES(CYC[3])) uut (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .adc_in, .adc_start, .adc_mux, .dac_out, .irq);
  adc_model conv (.mclk, .rst_n, .adc_start, .adc_mux, .adc_in);

  always #(`MCLK_PERIOD_NS / 2) mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  // ****
  // Checking
  // ****
  task automatic fail(input string m);
    errors++;
    $display("ERROR %0t: %s", $time, m);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_apb(input logic [32:0] g, input logic [32:0] x);
    num_checks++;
    if (g !== x) fail($sformatf("bus got %h exp %h", g, x));
  endtask
  task automatic chk_dac(input logic [17:0] g, input logic [17:0] x);
    num_checks++;
    if (g !== x) fail($sformatf("output got %h exp %h", g, x));
  endtask
  task automatic chk_val(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) fail($sformatf("value got %0d exp %0d", g, x));
  endtask

  always @(negedge mclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected bus answer");
      else begin
        e = exp_q.pop_front();
        chk_apb({pslverr, e[33] ? prdata : 32'h0}, e[32:0]);
      end
    end
    if (dac_out.load !== 2'b00) begin
      if (dac_q.size() == 0) fail("unexpected output load");
      else begin
        f = dac_q.pop_front();
        chk_dac({dac_out.load, dac_out.value[f[17]]}, f);
      end
    end
  end

  // ****
  // Drivers
  // ****
  function automatic logic [15:0] adr(input logic [3:0] x);
    return `SLOT_BASE + {10'h000, x, 2'b00};
  endfunction
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [33:0] x);
    int n;
    n = 0;
    exp_q.push_back(x);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail("bus timeout");
      final_report();
    end
  endtask
  task automatic w8(input int s, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((s == 0 ? adc_start : s == 1 ? adc_in.done : irq) !== 1'b1
               && n < lim);
    if (n >= lim) begin
      fail("wait timeout");
      final_report();
    end
  endtask

  initial begin
    static logic [15:0] bad [4] = '{16'hC001, 16'hC004, 16'hC040,
                                    16'h8000};
    static logic [2:0]  code [4] = '{`TA_CODE0, `TA_CODE1, `TA_CODE2,
                                     `TA_CODE3};
    logic [31:0] d;
    int          i;
    int          k;
    int          t0;
    seed = 25;
    cyc = 0;
    errors = 0;
    num_checks = 0;
    rst_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 16'h0000;
    pwdata <= 32'h0000_0000;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk_val(dac_out.value, 32'h0000_0000);
    for (i = 0; i < 8; i++)
      apb(1'b0, adr(4'(2 * i)), 32'h0, {2'b10, 32'(i == 5)});
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      d = $random(seed);
      if (i % 3 < 2) dac_q.push_back({2'(1 << (i % 3)), d[15:4], 4'h0});
      apb(1'b1, adr(4'(2 * (i % 3))), d, 34'h0);
    end
    $display("test output load done");
    for (i = 0; i < 4; i++) begin
      apb(1'b0, bad[i], 32'h0, {2'b11, 32'h0});
      apb(1'b1, bad[i], $random(seed), {2'b01, 32'h0});
    end
    $display("test refusal done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, adr(`REG_SEL), 32'(i + 1), 34'h0);
      apb(1'b0, adr(`REG_SEL), 32'h0, {2'b10, 32'(i + 1)});
      apb(1'b1, adr(`REG_STAT), 32'h0, 34'h0);
      w8(0, 400);
      chk_val(32'(adc_mux), 32'(i));
      w8(1, 100);
      apb(1'b0, adr(`REG_STAT), 32'h0, {2'b10, 30'h0, i == 3, 1'b1});
      apb(1'b0, adr(4'(2 * i)), 32'h0,
          {2'b10, 16'h0, 12'h8A5, 2'b00, 2'(i)});
    end
    $display("test demand done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, adr(`REG_CFG), {16'h0, 2'b11, 11'h0, code[i]}, 34'h0);
      t0 = 0;
      for (k = 0; k < 5; k++) begin
        w8(0, 2000);
        chk_val(32'(adc_mux), 32'(k % 4));
        if (k == 0) t0 = cyc;
      end
      chk_val(32'(cyc - t0), 32'(CYC[i]));
      w8(2, 2000);
      apb(1'b1, adr(`REG_IACK), 32'h0, 34'h0);
      repeat (3) @(posedge mclk);
      chk_val(32'(irq), 32'h0);
      apb(1'b1, adr(`REG_CFG), 32'h0, 34'h0);
      repeat (400) @(posedge mclk);
    end
    $display("test auto cycle done");
    final_report();
  end
endmodule // aio_regs_tb_top
